//--- telemetry_scheduler_readout.sv
// Telemetry scheduler, rolling averages and aggregate block readout.
// Assumes a transaction engine on LINK_CLK delivering whole commands, and a converter on CLOCK.
// How it works
// - Every class A channel is sampled in turn before any lower class sample.
// - One lower class sample follows each A pass: the next B, or one C after each full B pass.
// - Input voltage priority bits 31:30 pick A, B, C; code 11 disables it.
// - Temperature priority bits 23:22 pick A, B, C; code 11 is invalid.
// - Output current priority bits 15:14 pick A, B, C; code 11 disables it.
// - Output voltage priority bits 7:6 pick A, B, C; code 11 disables it.
// - Averaging value N from 0 to 5 averages 2^N samples; 6 and 7 invalid.
// - Bits 47:40 read zero; host writes 03h into 39:32 and zeros elsewhere.
// - A disabled channel reports 0000h.
// - Temperature measurement can never be switched off.
// - Setup command D0h is a six byte read/write block, live, stored in NVM.
// - Command DAh is a read-only fourteen byte block of status and measurements.
// - Bits 111:96 and 95:80 of the telemetry block read zero.
// - Telemetry block holds vin, temperature, current, voltage, then the status word.
// - Writing an aggregate read command flags an invalid command fault.
// - Command DBh is a read-only seven byte block of current status bytes.
// - Status block: manufacturer, other, cml, temperature, input, current, voltage bytes.
// - Writing the status block leaves every asserted status bit alone.
`timescale 1ns/1ps
`default_nettype none

module telemetry_scheduler_readout
	import telemetry_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic LINK_CLK,
	input wire logic LINK_REQ,
	input wire logic LINK_WRITE,
	input wire logic [7:0] LINK_CODE,
	input wire logic [47:0] LINK_WDATA,
	output logic LINK_BUSY,
	output logic LINK_DONE,
	output logic [111:0] LINK_RDATA,
	output logic [3:0] LINK_RLEN,
	output logic ADC_START,
	output logic [1:0] ADC_CHANNEL,
	input wire logic ADC_DONE,
	input wire logic [15:0] ADC_DATA,
	input wire logic [47:0] NVM_SETUP,
	output logic [47:0] SETUP_VALUE,
	input wire logic [15:0] STATUS_WORD_IN,
	input wire logic [7:0] STATUS_MFR_IN,
	input wire logic [7:0] STATUS_OTHER_IN,
	input wire logic [7:0] STATUS_CML_IN,
	input wire logic [7:0] STATUS_TEMP_IN,
	input wire logic [7:0] STATUS_INPUT_IN,
	input wire logic [7:0] STATUS_IOUT_IN,
	input wire logic [7:0] STATUS_VOUT_IN,
	output logic INVALID_CMD_SET,
	output logic [15:0] MEAS_VOUT,
	output logic [15:0] MEAS_IOUT,
	output logic [15:0] MEAS_TEMP,
	output logic [15:0] MEAS_VIN
);
	// First channel at or above start whose mask bit is set; 4 means none
	function automatic logic [2:0] first_from(input logic [3:0] m, input logic [2:0] s);
		logic [2:0] r;
		r = 3'h4;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (m[i] && (3'(i) >= s)) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction
	// Same search, wrapping to channel 0 when nothing lies above start
	function automatic logic [2:0] first_wrap(input logic [3:0] m, input logic [2:0] s);
		logic [2:0] r;
		r = first_from(m, s);
		if (r[2]) begin
			r = first_from(m, 3'h0);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Link domain: command capture and answer return
	logic l_busy_q, l_req_tgl_q, l_write_q, l_ack_s1_q, l_ack_s2_q, l_ack_s3_q, l_done_q, c_ack_tgl_q;
	logic [7:0] l_code_q;
	logic [47:0] l_wdata_q;
	logic [111:0] l_rdata_q, c_rsp_q;
	logic [3:0] l_rlen_q, c_rlen_q;
	wire l_take = LINK_REQ && !l_busy_q;
	wire l_ack_seen = l_ack_s2_q ^ l_ack_s3_q;

	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			l_busy_q <= 1'b0;
			l_req_tgl_q <= 1'b0;
			l_write_q <= 1'b0;
			l_code_q <= 8'h00;
			l_wdata_q <= 48'h0;
		end else if (l_take) begin
			l_busy_q <= 1'b1;
			l_req_tgl_q <= ~l_req_tgl_q;
			l_write_q <= LINK_WRITE;
			l_code_q <= LINK_CODE;
			l_wdata_q <= LINK_WDATA;
		end else if (l_ack_seen) begin
			l_busy_q <= 1'b0;
		end
	end

	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			l_ack_s1_q <= 1'b0;
			l_ack_s2_q <= 1'b0;
			l_ack_s3_q <= 1'b0;
		end else begin
			l_ack_s1_q <= c_ack_tgl_q;
			l_ack_s2_q <= l_ack_s1_q;
			l_ack_s3_q <= l_ack_s2_q;
		end
	end
	// Core answer is held steady until the next request, so it is safe here
	always_ff @(posedge LINK_CLK or negedge RSTN) begin
		if (!RSTN) begin
			l_done_q <= 1'b0;
			l_rdata_q <= 112'h0;
			l_rlen_q <= LEN_NONE;
		end else begin
			l_done_q <= l_ack_seen;
			if (l_ack_seen) begin
				l_rdata_q <= c_rsp_q;
				l_rlen_q <= c_rlen_q;
			end
		end
	end

	assign LINK_BUSY = l_busy_q;
	assign LINK_DONE = l_done_q;
	assign LINK_RDATA = l_rdata_q;
	assign LINK_RLEN = l_rlen_q;
	////////////////////////////////////////////////////////////////////////
	// Core domain: command execution
	logic c_req_s1_q, c_req_s2_q, c_req_s3_q, c_loaded_q, invalid_q;
	logic [47:0] setup_q;
	logic [15:0] meas_q [NUM_CH];
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			c_req_s1_q <= 1'b0;
			c_req_s2_q <= 1'b0;
			c_req_s3_q <= 1'b0;
		end else begin
			c_req_s1_q <= l_req_tgl_q;
			c_req_s2_q <= c_req_s1_q;
			c_req_s3_q <= c_req_s2_q;
		end
	end
	// Link command registers are static while the toggle is in flight
	wire c_req = c_req_s2_q ^ c_req_s3_q;
	wire hit_setup = (l_code_q == CODE_SETUP);
	wire hit_tele = (l_code_q == CODE_TELEMETRY);
	wire hit_status = (l_code_q == CODE_STATUS);
	wire wr_setup = c_req && l_write_q && hit_setup;
	wire wr_readonly = c_req && l_write_q && (hit_tele || hit_status);
	wire [111:0] tele_block = {UNSUPPORTED, meas_q[CH_VIN], meas_q[CH_TEMP],
		meas_q[CH_IOUT], meas_q[CH_VOUT], STATUS_WORD_IN};
	wire [55:0] status_block = {STATUS_MFR_IN, STATUS_OTHER_IN, STATUS_CML_IN,
		STATUS_TEMP_IN, STATUS_INPUT_IN, STATUS_IOUT_IN, STATUS_VOUT_IN};
	wire [111:0] rsp_d = hit_setup ? {64'h0, setup_q} :
		hit_tele ? tele_block :
		hit_status ? {56'h0, status_block} : 112'h0;
	wire [3:0] rlen_d = hit_setup ? LEN_SETUP : hit_tele ? LEN_TELEMETRY :
		hit_status ? LEN_STATUS : LEN_NONE;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			c_ack_tgl_q <= 1'b0;
			c_rsp_q <= 112'h0;
			c_rlen_q <= LEN_NONE;
			invalid_q <= 1'b0;
		end else begin
			invalid_q <= wr_readonly;
			if (c_req) begin
				c_ack_tgl_q <= ~c_ack_tgl_q;
				c_rsp_q <= l_write_q ? 112'h0 : rsp_d;
				c_rlen_q <= l_write_q ? LEN_NONE : rlen_d;
			end
		end
	end
	assign INVALID_CMD_SET = invalid_q;
	// Stored value loaded once after reset release, then live writes
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			c_loaded_q <= 1'b0;
			setup_q <= SETUP_RESET;
		end else if (!c_loaded_q) begin
			c_loaded_q <= 1'b1;
			setup_q <= {TOP_BYTE_VALUE, NVM_SETUP[TOP_LSB-1:0]};
		end else if (wr_setup) begin
			setup_q <= {TOP_BYTE_VALUE, l_wdata_q[TOP_LSB-1:0]};
		end
	end
	assign SETUP_VALUE = setup_q;
	////////////////////////////////////////////////////////////////////////
	// Channel configuration decode
	logic [1:0] pri_raw [NUM_CH], pri_eff [NUM_CH];
	logic [2:0] avg_raw [NUM_CH], avg_eff [NUM_CH];
	logic [3:0] mask_a, mask_b, mask_c, ch_on;
	assign pri_raw[CH_VOUT] = setup_q[VOUT_PRI_LSB+:2];
	assign pri_raw[CH_IOUT] = setup_q[IOUT_PRI_LSB+:2];
	assign pri_raw[CH_TEMP] = setup_q[TEMP_PRI_LSB+:2];
	assign pri_raw[CH_VIN] = setup_q[VIN_PRI_LSB+:2];
	assign avg_raw[CH_VOUT] = setup_q[VOUT_AVG_LSB+:3];
	assign avg_raw[CH_IOUT] = setup_q[IOUT_AVG_LSB+:3];
	assign avg_raw[CH_TEMP] = setup_q[TEMP_AVG_LSB+:3];
	assign avg_raw[CH_VIN] = setup_q[VIN_AVG_LSB+:3];
	for (genvar g = 0; g < NUM_CH; g++) begin : g_cfg
		// Invalid temperature code runs as class A so protection keeps its input
		assign pri_eff[g] = (g == CH_TEMP && pri_raw[g] == CLASS_OFF) ? CLASS_A : pri_raw[g];
		assign avg_eff[g] = (avg_raw[g] > AVG_MAX) ? AVG_MAX : avg_raw[g];
		assign mask_a[g] = (pri_eff[g] == CLASS_A);
		assign mask_b[g] = (pri_eff[g] == CLASS_B);
		assign mask_c[g] = (pri_eff[g] == CLASS_C);
		assign ch_on[g] = (pri_eff[g] != CLASS_OFF);
	end

	////////////////////////////////////////////////////////////////////////
	// Scheduler
	sched_state_type state_q;
	logic [2:0] ptr_a_q, ptr_b_q, ptr_c_q;
	logic owe_c_q, start_q;
	logic [1:0] chan_q;
	wire [2:0] a_pick = first_from(mask_a, ptr_a_q);
	wire [2:0] b_pick = first_wrap(mask_b, ptr_b_q);
	wire [2:0] c_pick = first_wrap(mask_c, ptr_c_q);
	wire [2:0] b_next = b_pick + 3'h1;
	wire [2:0] c_next = c_pick + 3'h1;
	wire [2:0] b_after = first_from(mask_b, b_next);
	wire b_last = b_after[2];
	wire b_any = |mask_b;
	wire c_any = |mask_c;
	wire a_open = !a_pick[2];
	wire low_c = c_any && (owe_c_q || !b_any);
	wire low_b = b_any && !low_c;
	wire pick_go = (state_q == ST_PICK) && (a_open || low_b || low_c);
	wire [2:0] pick_ch = a_open ? a_pick : low_b ? b_pick : c_pick;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state_q <= ST_PICK;
			ptr_a_q <= 3'h0;
			ptr_b_q <= 3'h0;
			ptr_c_q <= 3'h0;
			owe_c_q <= 1'b0;
		end else begin
			case (state_q)
				ST_PICK: begin
					if (a_open) begin
						ptr_a_q <= a_pick + 3'h1;
					end else begin
						ptr_a_q <= 3'h0;
						if (low_b) begin
							ptr_b_q <= b_last ? 3'h0 : b_next;
							owe_c_q <= b_last;
						end else if (low_c) begin
							ptr_c_q <= c_next;
							owe_c_q <= 1'b0;
						end
					end
					if (pick_go) begin
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (ADC_DONE) begin
						state_q <= ST_PICK;
					end
				end
				default: begin
					state_q <= ST_PICK;
				end
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			start_q <= 1'b0;
			chan_q <= CH_VOUT;
		end else begin
			start_q <= pick_go;
			if (pick_go) begin
				chan_q <= pick_ch[1:0];
			end
		end
	end
	assign ADC_START = start_q;
	assign ADC_CHANNEL = chan_q;
	////////////////////////////////////////////////////////////////////////
	// Rolling average over a per-channel ring of samples

	logic [15:0] ring [NUM_CH*AVG_SLOTS];
	logic [20:0] sum_q [NUM_CH];
	logic [5:0] fill_q [NUM_CH];
	logic [4:0] wptr_q [NUM_CH];
	logic [2:0] avg_seen_q [NUM_CH];
	logic [15:0] result_q [NUM_CH];

	wire sample = (state_q == ST_WAIT) && ADC_DONE;
	wire [2:0] n_cur = avg_eff[chan_q];
	wire [5:0] win = 6'h01 << n_cur;
	wire restart = (avg_seen_q[chan_q] != n_cur);
	wire full = (fill_q[chan_q] >= win);
	wire [4:0] old_slot = wptr_q[chan_q] - win[4:0];
	wire [15:0] old_val = full ? ring[{chan_q, old_slot}] : 16'h0;
	wire [20:0] sum_new = restart ? {5'h0, ADC_DATA} :
		sum_q[chan_q] + {5'h0, ADC_DATA} - {5'h0, old_val};
	wire [20:0] avg_new = sum_new >> n_cur;
	wire [5:0] fill_new = restart ? 6'h01 : (fill_q[chan_q] == FILL_FULL) ? FILL_FULL : fill_q[chan_q] + 6'h01;

	always_ff @(posedge CLOCK) begin
		if (sample) begin
			ring[{chan_q, wptr_q[chan_q]}] <= ADC_DATA;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			for (int i = 0; i < NUM_CH; i++) begin
				sum_q[i] <= 21'h0;
				fill_q[i] <= 6'h00;
				wptr_q[i] <= 5'h00;
				avg_seen_q[i] <= 3'h0;
				result_q[i] <= 16'h0000;
			end
		end else if (sample) begin
			sum_q[chan_q] <= sum_new;
			fill_q[chan_q] <= fill_new;
			wptr_q[chan_q] <= wptr_q[chan_q] + 5'h01;
			avg_seen_q[chan_q] <= n_cur;
			result_q[chan_q] <= avg_new[15:0];
		end
	end

	for (genvar g = 0; g < NUM_CH; g++) begin : g_meas
		always_ff @(posedge CLOCK or negedge RSTN) begin
			if (!RSTN) begin
				meas_q[g] <= MEAS_OFF;
			end else begin
				meas_q[g] <= ch_on[g] ? result_q[g] : MEAS_OFF;
			end
		end
	end

	assign MEAS_VOUT = meas_q[CH_VOUT];
	assign MEAS_IOUT = meas_q[CH_IOUT];
	assign MEAS_TEMP = meas_q[CH_TEMP];
	assign MEAS_VIN = meas_q[CH_VIN];

endmodule

`default_nettype wire

//--- telemetry_pkg.sv
// Constants shared by the telemetry scheduler and readout block.
// Assumes a command-level transaction engine outside that decodes bus frames.
package telemetry_pkg;

	// Command codes and block lengths in bytes
	localparam logic [7:0] CODE_SETUP = 8'hd0;
	localparam logic [7:0] CODE_TELEMETRY = 8'hda;
	localparam logic [7:0] CODE_STATUS = 8'hdb;
	localparam logic [3:0] LEN_SETUP = 4'h6;
	localparam logic [3:0] LEN_TELEMETRY = 4'he;
	localparam logic [3:0] LEN_STATUS = 4'h7;
	localparam logic [3:0] LEN_NONE = 4'h0;

	// Setup register layout
	localparam int SETUP_W = 48;
	localparam int TOP_MSB = 47;
	localparam int TOP_LSB = 40;
	localparam int VIN_PRI_LSB = 30;
	localparam int TEMP_PRI_LSB = 22;
	localparam int IOUT_PRI_LSB = 14;
	localparam int VOUT_PRI_LSB = 6;
	localparam int VIN_AVG_LSB = 24;
	localparam int TEMP_AVG_LSB = 16;
	localparam int IOUT_AVG_LSB = 8;
	localparam int VOUT_AVG_LSB = 0;
	localparam logic [7:0] TOP_BYTE_VALUE = 8'h00;
	localparam logic [47:0] SETUP_RESET = 48'h0003_0000_0000;

	// Priority classes
	localparam logic [1:0] CLASS_A = 2'h0;
	localparam logic [1:0] CLASS_B = 2'h1;
	localparam logic [1:0] CLASS_C = 2'h2;
	localparam logic [1:0] CLASS_OFF = 2'h3;

	// Channel numbers on the converter mux
	localparam logic [1:0] CH_VOUT = 2'h0;
	localparam logic [1:0] CH_IOUT = 2'h1;
	localparam logic [1:0] CH_TEMP = 2'h2;
	localparam logic [1:0] CH_VIN = 2'h3;
	localparam int NUM_CH = 4;

	// Averaging
	localparam logic [2:0] AVG_MAX = 3'h5;
	localparam int AVG_SLOTS = 32;
	localparam logic [5:0] FILL_FULL = 6'h20;
	localparam logic [15:0] MEAS_OFF = 16'h0000;
	localparam logic [31:0] UNSUPPORTED = 32'h0000_0000;

	typedef enum logic [0:0] {
		ST_PICK = 1'b0,
		ST_WAIT = 1'b1
	} sched_state_type;

endpackage

//--- telemetry_scheduler_readout_chk.sv
// Checker for the telemetry scheduler and readout block.
// Sees only top-level ports; bound below, both clock domains.
`timescale 1ns/1ps
`default_nettype none
module telemetry_scheduler_readout_chk
	import telemetry_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RSTN,
	input wire logic LINK_CLK,
	input wire logic LINK_REQ,
	input wire logic LINK_WRITE,
	input wire logic [7:0] LINK_CODE,
	input wire logic LINK_BUSY,
	input wire logic LINK_DONE,
	input wire logic [111:0] LINK_RDATA,
	input wire logic [3:0] LINK_RLEN,
	input wire logic ADC_START,
	input wire logic [1:0] ADC_CHANNEL,
	input wire logic [47:0] SETUP_VALUE,
	input wire logic INVALID_CMD_SET,
	input wire logic [15:0] MEAS_VIN
);
	wire take = LINK_REQ && !LINK_BUSY;
	wire take_rd = take && !LINK_WRITE;
	wire take_ro_wr = take && LINK_WRITE && (LINK_CODE == CODE_TELEMETRY || LINK_CODE == CODE_STATUS);
	logic [7:0] temp_gap_q;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN)
			temp_gap_q <= 8'h00;
		else if (ADC_START && ADC_CHANNEL == CH_TEMP)
			temp_gap_q <= 8'h00;
		else if (temp_gap_q != 8'hff)
			temp_gap_q <= temp_gap_q + 8'h01;
	end
	////////////////////////////////////////////////////////////////
	property p_off(logic [1:0] f, logic [1:0] ch);
		@(posedge CLOCK) disable iff (!RSTN) (f == CLASS_OFF) [*4] |-> !(ADC_START && ADC_CHANNEL == ch);
	endproperty
	a_tel_answer: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
		take_rd && LINK_CODE == CODE_TELEMETRY |-> ##[3:10] LINK_DONE && LINK_RLEN == LEN_TELEMETRY
		&& LINK_RDATA[111:80] == UNSUPPORTED) else $error("bad telemetry answer");
	a_stat_answer: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
		take_rd && LINK_CODE == CODE_STATUS |-> ##[3:10] LINK_DONE && LINK_RLEN == LEN_STATUS
		&& LINK_RDATA[111:56] == '0) else $error("bad status answer");
	a_setup_answer: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
		take_rd && LINK_CODE == CODE_SETUP |-> ##[3:10] LINK_DONE && LINK_RLEN == LEN_SETUP
		&& LINK_RDATA[111:40] == '0) else $error("bad setup answer");
	a_ro_write: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
		take_ro_wr |-> ##[3:10] LINK_DONE && LINK_RLEN == LEN_NONE) else $error("bad read-only write answer");
	a_done_pulse: assert property (@(posedge LINK_CLK) disable iff (!RSTN)
		LINK_DONE |-> !LINK_BUSY ##1 !LINK_DONE) else $error("done not a lone pulse");
	a_ivc_pulse: assert property (@(posedge CLOCK) disable iff (!RSTN)
		INVALID_CMD_SET |=> !INVALID_CMD_SET) else $error("invalid command flag not a pulse");
	a_top_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
		SETUP_VALUE[TOP_MSB:TOP_LSB] == TOP_BYTE_VALUE) else $error("setup top byte not zero");
	a_vin_skip: assert property (p_off(SETUP_VALUE[31:30], CH_VIN)) else $error("vin sampled while off");
	a_iout_skip: assert property (p_off(SETUP_VALUE[15:14], CH_IOUT)) else $error("iout sampled while off");
	a_vout_skip: assert property (p_off(SETUP_VALUE[7:6], CH_VOUT)) else $error("vout sampled while off");
	a_temp_alive: assert property (@(posedge CLOCK) disable iff (!RSTN)
		temp_gap_q < 8'hc8) else $error("temperature not sampled");
	a_vin_zero: assert property (@(posedge CLOCK) disable iff (!RSTN)
		(SETUP_VALUE[31:30] == CLASS_OFF) [*8] |-> MEAS_VIN == MEAS_OFF) else $error("disabled vin not zero");
	a_chan_hold: assert property (@(posedge CLOCK) disable iff (!RSTN)
		!ADC_START |-> $stable(ADC_CHANNEL)) else $error("channel moved between starts");
	c_tel_read: cover property (@(posedge LINK_CLK) disable iff (!RSTN) take_rd && LINK_CODE == CODE_TELEMETRY);
	c_ro_write: cover property (@(posedge LINK_CLK) disable iff (!RSTN) take_ro_wr);
	c_vin_start: cover property (@(posedge CLOCK) disable iff (!RSTN) ADC_START && ADC_CHANNEL == CH_VIN);
endmodule
bind telemetry_scheduler_readout telemetry_scheduler_readout_chk i_chk (.CLOCK, .RSTN, .LINK_CLK, .LINK_REQ,
	.LINK_WRITE, .LINK_CODE, .LINK_BUSY, .LINK_DONE, .LINK_RDATA, .LINK_RLEN, .ADC_START, .ADC_CHANNEL,
	.SETUP_VALUE, .INVALID_CMD_SET, .MEAS_VIN);
`default_nettype wire

//--- telemetry_host_model.sv
// Host model on the link side: one command at a time.
// Assumes the block's link port on LINK_CLK; released lines show inverted data.
`timescale 1ns/1ps
`default_nettype none
module telemetry_host_model (
	input wire logic LINK_CLK,
	input wire logic LINK_BUSY,
	input wire logic LINK_DONE,
	output logic LINK_REQ,
	output logic LINK_WRITE,
	output logic [7:0] LINK_CODE,
	output logic [47:0] LINK_WDATA
);
	initial begin
		LINK_REQ = 1'b0;
		LINK_WRITE = 1'b0;
		LINK_CODE = 8'h00;
		LINK_WDATA = 48'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] c, input logic [47:0] d, output bit ok);
		ok = 0;
		@(posedge LINK_CLK);
		LINK_REQ <= 1'b1;
		LINK_WRITE <= w;
		LINK_CODE <= c;
		LINK_WDATA <= d;
		@(posedge LINK_CLK);
		LINK_REQ <= 1'b0;
		for (int i = 0; i < 24 && !ok; i++) begin
			@(posedge LINK_CLK);
			#1;
			ok = (LINK_DONE === 1'b1);
		end
		LINK_CODE <= ~c;
		LINK_WDATA <= ~d;
	endtask
endmodule
`default_nettype wire

//--- telemetry_scheduler_readout_tb_top.sv
// Testbench: converter model, status sources and scheduled checks.
// Assumes the host model drives the link and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module telemetry_scheduler_readout_tb_top;
	import telemetry_pkg::*;
	logic CLOCK = 0, RSTN = 0, LINK_CLK = 0, ADC_DONE = 0, vtog = 0;
	logic LINK_REQ, LINK_WRITE, LINK_BUSY, LINK_DONE, ADC_START, INVALID_CMD_SET;
	logic [7:0] LINK_CODE;
	logic [47:0] LINK_WDATA, SETUP_VALUE, NVM_SETUP = 48'hff03_c080_4000;
	logic [111:0] LINK_RDATA;
	logic [3:0] LINK_RLEN;
	logic [1:0] ADC_CHANNEL, pch;
	logic [15:0] ADC_DATA = 0, STATUS_WORD_IN = 0, MEAS_VOUT, MEAS_IOUT, MEAS_TEMP, MEAS_VIN, dbase;
	logic [55:0] st = 0;
	logic [2:0] pcnt = 0;
	logic [1:0] seq[$];
	int fails = 0, checks_done = 0, ivc = 0;
	bit ok;
	logic [47:0] cfg[4] = '{48'h0003_c080_4000, 48'h0003_8040_0000, 48'h0003_c0c0_c0c0, 48'h0003_8001_4001};
	logic [11:0] pat[4] = '{12'h084, 12'hd24, 12'h002, 12'he18};
	int plen[4] = '{4, 6, 1, 6};
	telemetry_scheduler_readout i_dut (.CLOCK, .RSTN, .LINK_CLK, .LINK_REQ, .LINK_WRITE, .LINK_CODE,
		.LINK_WDATA, .LINK_BUSY, .LINK_DONE, .LINK_RDATA, .LINK_RLEN, .ADC_START, .ADC_CHANNEL, .ADC_DONE,
		.ADC_DATA, .NVM_SETUP, .SETUP_VALUE, .STATUS_WORD_IN, .STATUS_MFR_IN(st[55:48]),
		.STATUS_OTHER_IN(st[47:40]), .STATUS_CML_IN(st[39:32]), .STATUS_TEMP_IN(st[31:24]),
		.STATUS_INPUT_IN(st[23:16]), .STATUS_IOUT_IN(st[15:8]), .STATUS_VOUT_IN(st[7:0]),
		.INVALID_CMD_SET, .MEAS_VOUT, .MEAS_IOUT, .MEAS_TEMP, .MEAS_VIN);
	telemetry_host_model i_host (.LINK_CLK, .LINK_BUSY, .LINK_DONE, .LINK_REQ, .LINK_WRITE, .LINK_CODE,
		.LINK_WDATA);
	initial forever #20 CLOCK = ~CLOCK;
	initial begin
		#7;
		forever #80 LINK_CLK = ~LINK_CLK;
	end
	////////////////////////////////////////////////////////////////
	// Converter: answers two cycles after a start, vout alternates
	always @(posedge CLOCK) begin
		if (ADC_START === 1'b1) begin
			seq.push_back(ADC_CHANNEL);
			pch <= ADC_CHANNEL;
			pcnt <= 3'd2;
		end else if (pcnt != 3'd0)
			pcnt <= pcnt - 3'd1;
		if (pcnt == 3'd1) begin
			ADC_DONE <= 1'b1;
			ADC_DATA <= dbase + {6'h0, pch, 8'h0} + ((pch == CH_VOUT && vtog) ? 16'h0010 : 16'h0);
			vtog <= vtog ^ (pch == CH_VOUT);
		end else begin
			ADC_DONE <= 1'b0;
			ADC_DATA <= ~ADC_DATA;
		end
		if (INVALID_CMD_SET === 1'b1)
			ivc++;
	end
	////////////////////////////////////////////////////////////////
	task automatic end_sim();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [111:0] e, input logic [111:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cmd(input logic w, input logic [7:0] c, input logic [47:0] d);
		i_host.xfer(w, c, d, ok);
		chk("answer", 112'h1, 112'(ok));
	endtask
	task automatic wait_starts(input int n);
		seq.delete();
		for (int i = 0; i < 4000 && seq.size() < n; i++)
			@(posedge CLOCK);
	endtask
	function automatic bit rot_ok(input logic [11:0] p, input int n);
		bit m;
		for (int r = 0; r < n; r++) begin
			m = 1;
			for (int i = 0; i < 12; i++)
				if (seq[i] !== p[2 * ((i + r) % n) +: 2])
					m = 0;
			if (m)
				return 1;
		end
		return 0;
	endfunction
	initial begin
		#500000;
		fails++;
		end_sim();
	end
	initial begin
		dbase = 16'($urandom(6)) & 16'h0ee0;
		@(posedge CLOCK);
		st <= 56'({$urandom, $urandom});
		STATUS_WORD_IN <= 16'($urandom);
		repeat (7) @(posedge CLOCK);
		RSTN <= 1'b1;
		repeat (3) @(posedge CLOCK);
		chk("nvm load", 112'(NVM_SETUP[39:0]), 112'(SETUP_VALUE));
		cmd(1'b0, CODE_SETUP, 48'h0);
		chk("d0 data", 112'(NVM_SETUP[39:0]), LINK_RDATA);
		chk("d0 len", 112'(LEN_SETUP), 112'(LINK_RLEN));
		cmd(1'b1, CODE_TELEMETRY, 48'($urandom));
		cmd(1'b1, CODE_STATUS, 48'($urandom));
		repeat (4) @(posedge CLOCK);
		chk("ivc", 112'h2, 112'(ivc));
		cmd(1'b0, CODE_STATUS, 48'h0);
		chk("db data", 112'(st), LINK_RDATA);
		chk("db len", 112'(LEN_STATUS), 112'(LINK_RLEN));
		for (int k = 0; k < 4; k++) begin
			cmd(1'b1, CODE_SETUP, cfg[k]);
			chk("setup", 112'(cfg[k]), 112'(SETUP_VALUE));
			wait_starts(8);
			wait_starts(12);
			chk("order", 112'h1, 112'(rot_ok(pat[k], plen[k])));
			chk("temp", 112'(dbase + 16'h0200), 112'(MEAS_TEMP));
			if (cfg[k][31:30] == CLASS_OFF)
				chk("vin off", 112'h0, 112'(MEAS_VIN));
			if (cfg[k][15:14] == CLASS_OFF)
				chk("iout off", 112'h0, 112'(MEAS_IOUT));
			if (cfg[k][7:6] == CLASS_OFF)
				chk("vout off", 112'h0, 112'(MEAS_VOUT));
		end
		cmd(1'b0, CODE_TELEMETRY, 48'h0);
		chk("da data", {32'h0, dbase + 16'h0300, dbase + 16'h0200, dbase + 16'h0100, dbase + 16'h0008,
			STATUS_WORD_IN}, LINK_RDATA);
		chk("da len", 112'(LEN_TELEMETRY), 112'(LINK_RLEN));
		end_sim();
	end
endmodule
`default_nettype wire
